// ---- trl_run_length_check.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "trl_map.svh"

module trl_run_length_check #(
  parameter int SAMPLE_BITS = `TRL_SAMPLE_BITS
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire trl_pkg::trl_addr_type addr,
  input  wire logic [31:0]         wdata,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  output logic [31:0]              rdata,
  input  wire logic                raw_bit,
  input  wire logic                raw_bit_valid,
  input  wire logic [15:0]         other_fail,
  output logic                     entropy_valid,
  output logic                     gen_error,
  output logic                     program_mode
);
  import trl_pkg::*;

  trl_state_type       state_ff;
  logic                prog_ff;
  logic                valid_ff;
  logic                err_ff;
  trl_rty_type         retry_set_ff;
  trl_rty_type         retry_cnt_ff;
  trl_cnt_type         r5_rng_ff;
  trl_cnt_type         r5_max_ff;
  trl_cnt_type         r6_rng_ff;
  trl_cnt_type         r6_max_ff;
  trl_cnt_type         c5_one_ff;
  trl_cnt_type         c5_zero_ff;
  trl_cnt_type         c6_one_ff;
  trl_cnt_type         c6_zero_ff;
  logic [15:0]         fail_ff;
  logic [31:0]         rdata_ff;
  logic [15:0]         bit_cnt_ff;
  logic [3:0]          own_fail;
  logic [15:0]         nxt_fail;
  logic                any_fail;
  logic                wr_ctl;
  logic                wr_misc;
  logic                restore;
  logic                start_gen;
  logic                last_bit;
  logic [31:0]         nxt_rdata;
  trl_run_if run_bus ();

  // ======================================================================
  // helpers
  function automatic logic [31:0] pack_pair(input trl_cnt_type hi, input trl_cnt_type lo);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`TRL_HI_MSB:`TRL_HI_LSB] = hi;
    w[`TRL_LO_MSB:`TRL_LO_LSB] = lo;
    return w;
  endfunction

  // count = max - runs; a run closed by the last bit is one event behind the
  // counter in CHECK, so ev takes it off first (runs < max, runs > max - range)
  function automatic logic test_pass(input trl_cnt_type cnt, input logic ev, input trl_cnt_type rng);
    return (cnt > trl_cnt_type'(ev)) && (cnt - trl_cnt_type'(ev) < rng);
  endfunction

  function automatic trl_cnt_type dec_sat(input trl_cnt_type cnt);
    return (cnt == '0) ? cnt : cnt - trl_cnt_type'(1);
  endfunction

  // ======================================================================
  // decode
  assign wr_ctl    = wr_en && addr == `TRL_OFS_MISC_CTL;
  assign wr_misc   = wr_en && addr == `TRL_OFS_STAT_MISC;
  assign restore   = wr_ctl && wdata[`TRL_BIT_RESTORE_DEFAULTS];
  assign start_gen = state_ff == TRL_IDLE && !prog_ff;
  assign last_bit  = raw_bit_valid && bit_cnt_ff == 16'(SAMPLE_BITS - 1);

  assign own_fail[0] = !test_pass(c5_zero_ff, run_bus.len5_zero, r5_rng_ff);
  assign own_fail[1] = !test_pass(c5_one_ff, run_bus.len5_one, r5_rng_ff);
  assign own_fail[2] = !test_pass(c6_zero_ff, run_bus.len6_zero, r6_rng_ff);
  assign own_fail[3] = !test_pass(c6_one_ff, run_bus.len6_one, r6_rng_ff);

  always_comb begin
    nxt_fail = other_fail;
    nxt_fail[`TRL_FAIL_5_ZERO]  = own_fail[0];
    nxt_fail[`TRL_FAIL_5_ONE]   = own_fail[1];
    nxt_fail[`TRL_FAIL_6P_ZERO] = own_fail[2];
    nxt_fail[`TRL_FAIL_6P_ONE]  = own_fail[3];
  end

  assign any_fail = |nxt_fail;

  // ======================================================================
  // detector hookup
  assign run_bus.sample_bit   = raw_bit;
  assign run_bus.sample_valid = raw_bit_valid && state_ff == TRL_SAMPLE;
  assign run_bus.clear        = state_ff != TRL_SAMPLE;

  trl_run_detector u_detector (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (run_bus.detector)
  );

  // ======================================================================
  // control register: mode select
  always_ff @(posedge clk) begin
    if (!rst_n)
      prog_ff <= 1'b1;
    else if (wr_ctl)
      prog_ff <= wdata[`TRL_BIT_PROG];
  end

  // ======================================================================
  // generation sequence
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= TRL_IDLE;
    end else begin
      unique case (state_ff)
        TRL_IDLE: begin
          if (!prog_ff)
            state_ff <= TRL_SAMPLE;
        end
        TRL_SAMPLE: begin
          if (prog_ff)
            state_ff <= TRL_IDLE;
          else if (last_bit)
            state_ff <= TRL_CHECK;
        end
        TRL_CHECK: begin
          // retry restarts sampling with freshly loaded counters
          if (any_fail && retry_cnt_ff != '0)
            state_ff <= TRL_SAMPLE;
          else
            state_ff <= TRL_DONE;
        end
        TRL_DONE: begin
          if (prog_ff)
            state_ff <= TRL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || state_ff != TRL_SAMPLE)
      bit_cnt_ff <= 16'h0000;
    else if (raw_bit_valid)
      bit_cnt_ff <= bit_cnt_ff + 16'h0001;
  end

  // ======================================================================
  // completion flags
  always_ff @(posedge clk) begin
    if (!rst_n || prog_ff)
      valid_ff <= 1'b0;
    else if (state_ff == TRL_CHECK && !(any_fail && retry_cnt_ff != '0))
      valid_ff <= 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n || start_gen)
      err_ff <= 1'b0;
    else if (state_ff == TRL_CHECK && any_fail && retry_cnt_ff == '0)
      err_ff <= 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n || start_gen)
      fail_ff <= 16'h0000;
    else if (state_ff == TRL_CHECK)
      fail_ff <= nxt_fail;
  end

  // ======================================================================
  // retry setting and remaining retries
  always_ff @(posedge clk) begin
    if (!rst_n)
      retry_set_ff <= `TRL_DEF_RETRY;
    else if (wr_misc)
      retry_set_ff <= wdata[`TRL_RTY_MSB:`TRL_RTY_LSB];
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      retry_cnt_ff <= `TRL_DEF_RETRY;
    else if (wr_misc)
      retry_cnt_ff <= wdata[`TRL_RTY_MSB:`TRL_RTY_LSB];
    else if (start_gen)
      retry_cnt_ff <= retry_set_ff;
    else if (state_ff == TRL_CHECK && any_fail && retry_cnt_ff != '0)
      retry_cnt_ff <= retry_cnt_ff - trl_rty_type'(1);
  end

  // ======================================================================
  // limit registers, writable only in program mode; restore defaults reloads them in any mode
  always_ff @(posedge clk) begin
    if (!rst_n || restore) begin
      r5_rng_ff <= `TRL_DEF_RANGE;
      r5_max_ff <= `TRL_DEF_MAX;
    end else if (wr_en && prog_ff && addr == `TRL_OFS_RUN5) begin
      r5_rng_ff <= wdata[`TRL_HI_MSB:`TRL_HI_LSB];
      r5_max_ff <= wdata[`TRL_LO_MSB:`TRL_LO_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || restore) begin
      r6_rng_ff <= `TRL_DEF_RANGE;
      r6_max_ff <= `TRL_DEF_MAX;
    end else if (wr_en && prog_ff && addr == `TRL_OFS_RUN6P) begin
      r6_rng_ff <= wdata[`TRL_HI_MSB:`TRL_HI_LSB];
      r6_max_ff <= wdata[`TRL_LO_MSB:`TRL_LO_LSB];
    end
  end

  // ======================================================================
  // run counters; reloaded from max at every pass, so a retry starts clean
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      c5_one_ff  <= '0;
      c5_zero_ff <= '0;
    end else if (start_gen || (state_ff == TRL_CHECK && any_fail && retry_cnt_ff != '0)) begin
      c5_one_ff  <= r5_max_ff;
      c5_zero_ff <= r5_max_ff;
    end else begin
      if (run_bus.len5_one)
        c5_one_ff <= dec_sat(c5_one_ff);
      if (run_bus.len5_zero)
        c5_zero_ff <= dec_sat(c5_zero_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      c6_one_ff  <= '0;
      c6_zero_ff <= '0;
    end else if (start_gen || (state_ff == TRL_CHECK && any_fail && retry_cnt_ff != '0)) begin
      c6_one_ff  <= r6_max_ff;
      c6_zero_ff <= r6_max_ff;
    end else begin
      if (run_bus.len6_one)
        c6_one_ff <= dec_sat(c6_one_ff);
      if (run_bus.len6_zero)
        c6_zero_ff <= dec_sat(c6_zero_ff);
    end
  end

  // ======================================================================
  // read mux; writes to count and status addresses fall through unused
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (addr)
      `TRL_OFS_MISC_CTL: begin
        nxt_rdata[`TRL_BIT_PROG]    = prog_ff;
        nxt_rdata[`TRL_BIT_ENTROPY_VALID] = valid_ff;
        nxt_rdata[`TRL_BIT_ERR]     = err_ff;
      end
      `TRL_OFS_STAT_MISC: begin
        nxt_rdata[`TRL_RTY_MSB:`TRL_RTY_LSB] = retry_set_ff;
      end
      `TRL_OFS_RUN5: begin
        nxt_rdata = prog_ff ? pack_pair(r5_rng_ff, r5_max_ff)
                            : pack_pair(c5_one_ff, c5_zero_ff);
      end
      `TRL_OFS_RUN6P: begin
        nxt_rdata = prog_ff ? pack_pair(r6_rng_ff, r6_max_ff)
                            : pack_pair(c6_one_ff, c6_zero_ff);
      end
      `TRL_OFS_STATUS: begin
        if (!prog_ff) begin
          nxt_rdata[`TRL_FAIL_W-1:0]           = fail_ff;
          nxt_rdata[`TRL_RTY_MSB:`TRL_RTY_LSB] = retry_cnt_ff;
        end
      end
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      rdata_ff <= 32'h0000_0000;
    else if (rd_en)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= 32'h0000_0000;
  end

  assign rdata         = rdata_ff;
  assign entropy_valid = valid_ff;
  assign gen_error     = err_ff;
  assign program_mode  = prog_ff;

  // ======================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_check_fail_retry;
    state_ff == TRL_CHECK && any_fail && retry_cnt_ff != '0;
  endsequence
  sequence s_retry_effect(logic [3:0] r);
    state_ff == TRL_SAMPLE && retry_cnt_ff == r - 4'h1;
  endsequence
  AST_RETRY_RESTART: assert property (
    s_check_fail_retry |=> s_retry_effect($past(retry_cnt_ff)))
    else $error("retry did not restart sampling with one retry fewer");
  AST_ERROR_NO_RETRY: assert property (
    state_ff == TRL_CHECK && any_fail && retry_cnt_ff == '0 |=> err_ff && state_ff == TRL_DONE)
    else $error("failure with no retries left did not raise error");
  AST_STATUS_PROG_ZERO: assert property (
    rd_en && addr == `TRL_OFS_STATUS && prog_ff |=> rdata == 32'h0000_0000)
    else $error("status read in program mode was not zero");
  AST_STATUS_RETRY_FIELD: assert property (
    rd_en && addr == `TRL_OFS_STATUS && !prog_ff
      |=> rdata[`TRL_RTY_MSB:`TRL_RTY_LSB] == $past(retry_cnt_ff))
    else $error("status retry field wrong");
  AST_RUN5_READ: assert property (
    rd_en && addr == `TRL_OFS_RUN5
      |=> rdata == ($past(prog_ff) ? pack_pair($past(r5_rng_ff), $past(r5_max_ff))
                                   : pack_pair($past(c5_one_ff), $past(c5_zero_ff))))
    else $error("length-5 address read wrong register");
  AST_RUN6_READ: assert property (
    rd_en && addr == `TRL_OFS_RUN6P && !prog_ff
      |=> rdata == pack_pair($past(c6_one_ff), $past(c6_zero_ff)))
    else $error("length-6+ counts read wrong");
  AST_RESTORE_DEFAULTS: assert property (
    restore |=> r5_rng_ff == `TRL_DEF_RANGE && r5_max_ff == `TRL_DEF_MAX
             && r6_rng_ff == `TRL_DEF_RANGE && r6_max_ff == `TRL_DEF_MAX)
    else $error("restore defaults did not load limits");
  AST_LEN5_DEC: assert property (
    run_bus.len5_one && !start_gen && state_ff == TRL_SAMPLE && c5_one_ff != '0
      |=> c5_one_ff == $past(c5_one_ff) - 11'h001)
    else $error("length-5 ones counter did not decrement");
  AST_LEN6_DEC: assert property (
    run_bus.len6_zero && state_ff == TRL_SAMPLE && c6_zero_ff != '0
      |=> c6_zero_ff == $past(c6_zero_ff) - 11'h001)
    else $error("length-6+ zeros counter did not decrement");
  AST_PASS_FLAG: assert property (
    state_ff == TRL_CHECK |=> fail_ff[`TRL_FAIL_5_ONE]
      == !($past(c5_one_ff) > 11'($past(run_bus.len5_one))
           && $past(c5_one_ff) - 11'($past(run_bus.len5_one)) < $past(r5_rng_ff)))
    else $error("length-5 ones fail flag wrong");
endmodule

`default_nettype wire

// ---- trl_map.svh ----
`ifndef TRL_MAP_SVH
`define TRL_MAP_SVH

// ======================================================================
// register offsets
`define TRL_ADDR_W        12
`define TRL_OFS_MISC_CTL  12'h600
`define TRL_OFS_STAT_MISC 12'h604
`define TRL_OFS_RUN5      12'h634
`define TRL_OFS_RUN6P     12'h638
`define TRL_OFS_STATUS    12'h63C

// ======================================================================
// field layout of limit and count registers
`define TRL_FLD_W         11
`define TRL_HI_MSB        26
`define TRL_HI_LSB        16
`define TRL_LO_MSB        10
`define TRL_LO_LSB        0

// ======================================================================
// control register bits and retry field
`define TRL_BIT_PROG      0
`define TRL_BIT_RESTORE_DEFAULTS   1
`define TRL_BIT_ENTROPY_VALID   2
`define TRL_BIT_ERR       3
`define TRL_RTY_W         4
`define TRL_RTY_MSB       19
`define TRL_RTY_LSB       16

// ======================================================================
// status failure bits
`define TRL_FAIL_6P_ONE   11
`define TRL_FAIL_6P_ZERO  10
`define TRL_FAIL_5_ONE    9
`define TRL_FAIL_5_ZERO   8
`define TRL_FAIL_W        16

// ======================================================================
// defaults and run length constants
`define TRL_DEF_RANGE     11'h02E
`define TRL_DEF_MAX       11'h02F
`define TRL_DEF_RETRY     4'h1
`define TRL_SAMPLE_BITS   256
`define TRL_LEN_W         3
`define TRL_LEN_FIVE      3'h5
`define TRL_LEN_SIX       3'h6

`endif

// ---- trl_pkg.sv ----
`include "trl_map.svh"

package trl_pkg;
  typedef logic [`TRL_FLD_W-1:0] trl_cnt_type;
  typedef logic [`TRL_RTY_W-1:0] trl_rty_type;
  typedef logic [`TRL_ADDR_W-1:0] trl_addr_type;

  typedef enum logic [3:0] {
    TRL_IDLE   = 4'b0001,
    TRL_SAMPLE = 4'b0010,
    TRL_CHECK  = 4'b0100,
    TRL_DONE   = 4'b1000
  } trl_state_type;
endpackage

// ---- trl_run_if.sv ----
`timescale 1ns/10ps
`default_nettype none

interface trl_run_if;
  logic sample_bit;
  logic sample_valid;
  logic clear;
  logic len5_one;
  logic len5_zero;
  logic len6_one;
  logic len6_zero;

  modport detector (
    input  sample_bit, sample_valid, clear,
    output len5_one, len5_zero, len6_one, len6_zero
  );
  modport ctrl (
    output sample_bit, sample_valid, clear,
    input  len5_one, len5_zero, len6_one, len6_zero
  );
endinterface

`default_nettype wire

// ---- trl_run_detector.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "trl_map.svh"

module trl_run_detector (
  input wire logic  clk,
  input wire logic  rst_n,
  trl_run_if.detector run
);
  logic                  cur_ff;
  logic [`TRL_LEN_W-1:0] len_ff;
  logic                  started_ff;
  logic                  bounded_ff;

  // ======================================================================
  // run tracking; a run only counts once an opposite bit precedes it
  always_ff @(posedge clk) begin
    if (!rst_n || run.clear) begin
      cur_ff     <= 1'b0;
      len_ff     <= '0;
      started_ff <= 1'b0;
      bounded_ff <= 1'b0;
    end else if (run.sample_valid) begin
      if (!started_ff) begin
        cur_ff     <= run.sample_bit;
        len_ff     <= `TRL_LEN_W'(1);
        started_ff <= 1'b1;
      end else if (run.sample_bit == cur_ff) begin
        // saturate: six and longer look the same
        if (len_ff != `TRL_LEN_SIX)
          len_ff <= len_ff + `TRL_LEN_W'(1);
      end else begin
        cur_ff     <= run.sample_bit;
        len_ff     <= `TRL_LEN_W'(1);
        bounded_ff <= 1'b1;
      end
    end
  end

  // ======================================================================
  // one-cycle events when a bounded run closes
  always_ff @(posedge clk) begin
    if (!rst_n || run.clear) begin
      run.len5_one  <= 1'b0;
      run.len5_zero <= 1'b0;
      run.len6_one  <= 1'b0;
      run.len6_zero <= 1'b0;
    end else begin
      run.len5_one  <= 1'b0;
      run.len5_zero <= 1'b0;
      run.len6_one  <= 1'b0;
      run.len6_zero <= 1'b0;
      if (run.sample_valid && started_ff && bounded_ff && run.sample_bit != cur_ff) begin
        run.len5_one  <= cur_ff && len_ff == `TRL_LEN_FIVE;
        run.len5_zero <= !cur_ff && len_ff == `TRL_LEN_FIVE;
        run.len6_one  <= cur_ff && len_ff == `TRL_LEN_SIX;
        run.len6_zero <= !cur_ff && len_ff == `TRL_LEN_SIX;
      end
    end
  end
endmodule

`default_nettype wire

// ---- tb_trl_run_length_check.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "trl_map.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; $display("mismatch %s expected %h seen %h", n, e, g); end end

module tb_trl_run_length_check;
  import trl_pkg::*;
  // a short sample keeps each generation near a hundred cycles
  localparam int NBITS = 16;

  logic         clk           = 1'b0;
  logic         rst_n         = 1'b0;
  trl_addr_type addr          = '0;
  logic [31:0]  wdata         = '0;
  logic         wr_en         = 1'b0;
  logic         rd_en         = 1'b0;
  logic [31:0]  rdata;
  logic         raw_bit       = 1'b0;
  logic         raw_bit_valid = 1'b0;
  logic [15:0]  other_fail    = '0;
  logic         entropy_valid;
  logic         gen_error;
  logic         program_mode;
  int           bad_count     = 0;
  int           checked       = 0;

  always #4 clk = ~clk;

  trl_run_length_check #(.SAMPLE_BITS(NBITS)) uut (
    .clk           (clk),
    .rst_n         (rst_n),
    .addr          (addr),
    .wdata         (wdata),
    .wr_en         (wr_en),
    .rd_en         (rd_en),
    .rdata         (rdata),
    .raw_bit       (raw_bit),
    .raw_bit_valid (raw_bit_valid),
    .other_fail    (other_fail),
    .entropy_valid (entropy_valid),
    .gen_error     (gen_error),
    .program_mode  (program_mode)
  );

  // ======================================================================
  // register bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    `CHK(n, e, d)
  endtask

  // ======================================================================
  // sample stream, bit 0 first
  task automatic feed(input logic [15:0] s);
    for (int i = 0; i < NBITS; i++) begin
      @(posedge clk);
      raw_bit <= s[i];
      raw_bit_valid <= 1'b1;
    end
    @(posedge clk);
    raw_bit_valid <= 1'b0;
    raw_bit <= ~s[NBITS-1];
    repeat (8) @(posedge clk);
  endtask

  // ======================================================================
  // expectations
  // n: 0 five ones, 1 five zeros, 2 six-plus ones, 3 six-plus zeros
  function automatic void tally(input logic [15:0] s, output int n[4]);
    int i;
    int j;
    n = '{default: 0};
    i = 0;
    while (i < NBITS) begin
      j = i;
      while (j < NBITS - 1 && s[j+1] == s[i])
        j++;
      // runs touching either end of the sample are not bounded
      if (i > 0 && j < NBITS - 1) begin
        if (j - i + 1 == 5)
          n[s[i] ? 0 : 1]++;
        else if (j - i + 1 >= 6)
          n[s[i] ? 2 : 3]++;
      end
      i = j + 1;
    end
  endfunction

  function automatic logic [10:0] left(input logic [10:0] mx, input int r);
    return (r >= int'(mx)) ? 11'h000 : mx - 11'(r);
  endfunction

  function automatic logic bad(input logic [10:0] mx, input logic [10:0] rg, input int r);
    return !(r < int'(mx) && r > int'(mx) - int'(rg));
  endfunction

  // ======================================================================
  // one generation with retries
  task automatic run_gen(input int it);
    logic [10:0] mx5, rg5, mx6, rg6;
    logic [10:0] e[4];
    logic [15:0] s, of;
    logic [3:0]  rty, fl;
    logic [31:0] d;
    logic        fail;
    int          n[4];
    // round 1 has only one-bit runs and loose limits, so it must pass
    mx5 = (it == 0) ? 11'h002 : (it == 1) ? 11'h001 : 11'($urandom_range(4));
    rg5 = (it < 2) ? 11'h002 : 11'($urandom_range(4));
    mx6 = (it == 0) ? 11'h002 : (it == 1) ? 11'h001 : 11'($urandom_range(4));
    rg6 = (it < 2) ? 11'h002 : 11'($urandom_range(4));
    s = (it == 0) ? 16'b0100_0000_0111_1100 : (it == 1) ? 16'h5555 : 16'($urandom);
    // even rounds only touch the bits that this block overrides
    of = (it == 1) ? 16'h0000 : it[0] ? 16'($urandom) : {4'h0, 4'($urandom), 8'h00};
    rty = 4'($urandom_range(1, 2));
    tally(s, n);
    e[0] = left(mx5, n[0]);
    e[1] = left(mx5, n[1]);
    e[2] = left(mx6, n[2]);
    e[3] = left(mx6, n[3]);
    fl = {bad(mx6, rg6, n[2]), bad(mx6, rg6, n[3]), bad(mx5, rg5, n[0]), bad(mx5, rg5, n[1])};
    fail = (|fl) || (|of[15:12]) || (|of[7:0]);
    wr(`TRL_OFS_RUN5, {5'h1F, rg5, 5'h1F, mx5});
    wr(`TRL_OFS_RUN6P, {5'h1F, rg6, 5'h1F, mx6});
    wr(`TRL_OFS_STAT_MISC, {12'h000, rty, 16'h0000});
    rdc("retry setting", `TRL_OFS_STAT_MISC, {12'h000, rty, 16'h0000});
    rdc("len5 limit", `TRL_OFS_RUN5, {5'h00, rg5, 5'h00, mx5});
    rdc("len6 limit", `TRL_OFS_RUN6P, {5'h00, rg6, 5'h00, mx6});
    @(posedge clk);
    other_fail <= of;
    wr(`TRL_OFS_MISC_CTL, 32'h0000_0000);
    repeat (4) @(posedge clk);
    `CHK("program mode", 1'b0, program_mode)
    // enough copies for every permitted retry to see the same data
    for (int k = 0; k < 3; k++)
      feed(s);
    for (int t = 0; t < 20 && entropy_valid !== 1'b1 && gen_error !== 1'b1; t++)
      @(posedge clk);
    #1;
    `CHK("error", fail, gen_error)
    if (!fail)
      `CHK("entropy valid", 1'b1, entropy_valid)
    rdc("len5 counts", `TRL_OFS_RUN5, {5'h00, e[0], 5'h00, e[1]});
    rdc("len6 counts", `TRL_OFS_RUN6P, {5'h00, e[2], 5'h00, e[3]});
    rd(`TRL_OFS_STATUS, d);
    // failure flags carry meaning only beside an error
    if (!fail)
      d[15:0] = 16'h0000;
    `CHK("status", fail ? {12'h000, 4'h0, of[15:12], fl, of[7:0]} : {12'h000, rty, 16'h0000}, d)
    wr(`TRL_OFS_RUN5, 32'($urandom));
    wr(`TRL_OFS_STATUS, 32'($urandom));
    rdc("len5 counts kept", `TRL_OFS_RUN5, {5'h00, e[0], 5'h00, e[1]});
    wr(`TRL_OFS_MISC_CTL, 32'h0000_0001);
    rdc("status program", `TRL_OFS_STATUS, 32'h0000_0000);
    `CHK("valid cleared", 1'b0, entropy_valid)
  endtask

  // ======================================================================
  // verdict
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #(8 * 20000);
    bad_count++;
    conclude();
  end

  initial begin
    void'($urandom(32'h5c98d16d));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rdc("control", `TRL_OFS_MISC_CTL, 32'h0000_0001);
    rdc("len5 reset", `TRL_OFS_RUN5, 32'h002E_002F);
    rdc("len6 reset", `TRL_OFS_RUN6P, 32'h002E_002F);
    rdc("retry reset", `TRL_OFS_STAT_MISC, 32'h0001_0000);
    rdc("status reset", `TRL_OFS_STATUS, 32'h0000_0000);
    rdc("unmapped", 12'h7F0, 32'h0000_0000);
    wr(`TRL_OFS_RUN5, 32'hFFFF_FFFF);
    wr(`TRL_OFS_RUN6P, 32'hFFFF_FFFF);
    rdc("len5 reserved", `TRL_OFS_RUN5, 32'h07FF_07FF);
    rdc("len6 reserved", `TRL_OFS_RUN6P, 32'h07FF_07FF);
    wr(`TRL_OFS_MISC_CTL, 32'h0000_0003);
    rdc("len5 defaults", `TRL_OFS_RUN5, 32'h002E_002F);
    rdc("len6 defaults", `TRL_OFS_RUN6P, 32'h002E_002F);
    rdc("restore pulse", `TRL_OFS_MISC_CTL, 32'h0000_0001);
    for (int it = 0; it < 12; it++)
      run_gen(it);
    conclude();
  end
endmodule

`default_nettype wire
